// *** logic/serial_pkg.sv ***
// Purpose: Shared constants for the asynchronous serial core
// Assumes: Registers are one aligned 32-bit word each, byte address = index * 4
// Notes: Sample counter values are zero based, so RTn is stored as n-1
package serial_pkg;
  // Register indices
  localparam logic [5:0] IDX_CTRL_ONE = 6'h13;
  localparam logic [5:0] IDX_CTRL_TWO = 6'h14;
  localparam logic [5:0] IDX_CTRL_THREE = 6'h15;
  localparam logic [5:0] IDX_STATUS_ONE = 6'h16;
  localparam logic [5:0] IDX_STATUS_TWO = 6'h17;
  localparam logic [5:0] IDX_DATA = 6'h18;
  localparam logic [5:0] IDX_BAUD = 6'h19;
  localparam logic [5:0] IDX_RT_DIV = 6'h1A;
  // Field positions
  localparam int BIT_IF_EN = 6;
  localparam int BIT_TX_INV = 5;
  localparam int BIT_CHAR9 = 4;
  localparam int BIT_TE_IE = 7;
  localparam int BIT_TC_IE = 6;
  localparam int BIT_RF_IE = 5;
  localparam int BIT_TX_EN = 3;
  localparam int BIT_RX_EN = 2;
  localparam int BIT_SEND_BRK = 0;
  localparam int BIT_LONG_BRK = 6;
  // Reset values
  localparam logic [15:0] RT_DIV_RST = 16'h0036;
  // Character lengths in bits, start and stop included
  localparam logic [3:0] CHAR8_BITS = 4'hA;
  localparam logic [3:0] CHAR9_BITS = 4'hB;
  localparam logic [3:0] LONG_BRK_EXTRA = 4'h3;
  // Sample clock positions
  localparam logic [3:0] RT3 = 4'h2;
  localparam logic [3:0] RT5 = 4'h4;
  localparam logic [3:0] RT7 = 4'h6;
  localparam logic [3:0] RT8 = 4'h7;
  localparam logic [3:0] RT9 = 4'h8;
  localparam logic [3:0] RT10 = 4'h9;
  localparam logic [3:0] RT16 = 4'hF;

  function automatic logic [1:0] ones3(input logic [2:0] s);
    ones3 = {1'b0, s[0]} + {1'b0, s[1]} + {1'b0, s[2]};
  endfunction

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (ones3(s) >= 2'h2);
  endfunction
endpackage

// *** logic/sample_if.sv ***
// Purpose: Carrier between frame control and receive bit sampler
// Assumes: All signals on the system clock; strobes last one cycle
// Notes: None
`timescale 1ns/10ps
`default_nettype none
interface sample_if;
  logic rt_tick;
  logic rx_enable;
  logic frame_end;
  logic start_ok;
  logic start_noise;
  logic bit_stb;
  logic bit_val;
  logic bit_noise;
  modport ctrl(output rt_tick, rx_enable, frame_end,
               input start_ok, start_noise, bit_stb, bit_val, bit_noise);
  modport smp(input rt_tick, rx_enable, frame_end,
              output start_ok, start_noise, bit_stb, bit_val, bit_noise);
endinterface
`default_nettype wire

// *** logic/rt_divider.sv ***
// Purpose: Sample clock enable at sixteen times the baud rate
// Assumes: div is the number of system clocks per sample tick
// Notes: div of zero or one gives a tick every cycle
`timescale 1ns/10ps
`default_nettype none
module rt_divider #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else if (!en || div <= W'(1) || cnt_ff >= div - W'(1)) begin
      cnt_ff <= '0;
      tick <= en;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** logic/rx_sampler.sv ***
// Purpose: Start bit search, verification and majority sampling of the receive line
// Assumes: Frame control ends each frame with frame_end
// Notes: Pin passes three flops; a change counts once the last two agree
`timescale 1ns/10ps
`default_nettype none
module rx_sampler
  import serial_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rxd_pin,
  sample_if.smp sif
);
  typedef enum {SEARCH, START, BITS} smp_state_e;
  smp_state_e st_ff;
  logic meta_ff, s2_ff, s3_ff, clean_ff, prev_one_ff;
  logic [2:0] hist_ff, smp_ff;
  logic [3:0] cnt_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      clean_ff <= 1'b1;
    end else begin
      meta_ff <= rxd_pin;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) clean_ff <= s3_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= SEARCH;
      hist_ff <= 3'h0;
      smp_ff <= 3'h0;
      cnt_ff <= 4'h0;
      prev_one_ff <= 1'b0;
      sif.start_ok <= 1'b0;
      sif.start_noise <= 1'b0;
      sif.bit_stb <= 1'b0;
      sif.bit_val <= 1'b0;
      sif.bit_noise <= 1'b0;
    end else begin
      sif.start_ok <= 1'b0;
      sif.bit_stb <= 1'b0;
      if (!sif.rx_enable || sif.frame_end) begin
        st_ff <= SEARCH;
      end else if (sif.rt_tick) begin
        hist_ff <= {hist_ff[1:0], clean_ff};
        case (st_ff)
          SEARCH: begin
            if (!clean_ff && hist_ff == 3'h7) begin
              st_ff <= START;
              cnt_ff <= 4'h1;
            end
          end
          START: begin
            cnt_ff <= cnt_ff + 4'h1;
            prev_one_ff <= 1'b0;
            if (cnt_ff == RT3) smp_ff[2] <= clean_ff;
            if (cnt_ff == RT5) smp_ff[1] <= clean_ff;
            if (cnt_ff == RT7) begin
              if (ones3({smp_ff[2:1], clean_ff}) >= 2'h2) begin
                st_ff <= SEARCH;
              end else begin
                sif.start_ok <= 1'b1;
                sif.start_noise <= (ones3({smp_ff[2:1], clean_ff}) == 2'h1);
              end
            end
            if (cnt_ff == RT16) st_ff <= BITS;
          end
          BITS: begin
            cnt_ff <= cnt_ff + 4'h1;
            if (prev_one_ff && hist_ff[0] && !clean_ff && cnt_ff < RT8) begin
              cnt_ff <= 4'h1;
              prev_one_ff <= 1'b0;
            end
            if (cnt_ff == RT8) smp_ff[2] <= clean_ff;
            if (cnt_ff == RT9) smp_ff[1] <= clean_ff;
            if (cnt_ff == RT10) begin
              sif.bit_stb <= 1'b1;
              sif.bit_val <= maj3({smp_ff[2:1], clean_ff});
              sif.bit_noise <= (ones3({smp_ff[2:1], clean_ff}) == 2'h1) ||
                               (ones3({smp_ff[2:1], clean_ff}) == 2'h2);
              prev_one_ff <= maj3({smp_ff[2:1], clean_ff});
            end
          end
          default: st_ff <= SEARCH;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/serial_core.sv ***
// Purpose: Asynchronous serial transmitter and receiver with APB registers
// Assumes: APB3 slave, one wait state per transfer, 100 MHz system clock
// Notes: Sample tick comes from a programmable divider of the system clock
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module serial_core
  import serial_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD_IN,
  output logic TXD_OUT,
  output logic TXD_OE_N,
  output logic TX_IRQ,
  output logic RX_IRQ
);
  typedef enum {TX_IDLE, TX_PRE, TX_FRAME, TX_BREAK, TX_TAIL} tx_state_e;
  sample_if sif();
  logic [7:0] ctrl1_ff, ctrl2_ff, baud_ff, tx_buf_ff, rx_buf_ff;
  logic [15:0] rt_div_ff;
  logic tx_bit8_ff, rx_bit8_ff;
  logic tef_ff, tcf_ff, rff_ff, orf_ff, nf_ff, fe_ff, bkf_ff;
  logic arm1_ff, arm2_ff, rdy_ff, slverr_ff;
  logic [31:0] prdata_ff;
  logic [7:0] rd_mux;
  logic rt_tick, done, wr, rd, mapped, interface_enable, m9, inv;
  logic [5:0] idx;
  tx_state_e tx_st_ff;
  logic [13:0] tx_sh_ff;
  logic [3:0] tx_left_ff, tx_rt_ff, frame_len;
  logic te_q_ff, pre_pend_ff, load_frame, bit_tick, txd_ff, oe_n_ff;
  logic rx_act_ff, rx_extra_ff, rx_zero_ff, rx_noise_ff;
  logic [3:0] rx_cnt_ff;
  logic [8:0] rx_sh_ff;
  logic done_ff, done_brk_ff, done_fe_ff, done_nf_ff;
  logic rx_clr, rx_data_clr, tx_clr;

  assign interface_enable = ctrl1_ff[BIT_IF_EN];
  assign m9 = ctrl1_ff[BIT_CHAR9];
  assign inv = ctrl1_ff[BIT_TX_INV];
  assign frame_len = m9 ? CHAR9_BITS : CHAR8_BITS;

  // APB slave, one wait state
  assign idx = PADDR[7:2];
  assign mapped = (idx >= IDX_CTRL_ONE) && (idx <= IDX_RT_DIV) && (PADDR[1:0] == 2'h0);
  assign done = PSEL && PENABLE && rdy_ff;
  assign wr = done && PWRITE && mapped;
  assign rd = done && !PWRITE && mapped;
  assign PREADY = rdy_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = slverr_ff;

  always_comb begin
    case (idx)
      IDX_CTRL_ONE: rd_mux = ctrl1_ff;
      IDX_CTRL_TWO: rd_mux = ctrl2_ff;
      IDX_CTRL_THREE: rd_mux = {rx_bit8_ff, tx_bit8_ff, 6'h00};
      IDX_STATUS_ONE: rd_mux = {tef_ff, tcf_ff, rff_ff, 1'b0, orf_ff, nf_ff, fe_ff, 1'b0};
      IDX_STATUS_TWO: rd_mux = {6'h00, bkf_ff, rx_act_ff};
      IDX_DATA: rd_mux = rx_buf_ff;
      IDX_BAUD: rd_mux = baud_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rdy_ff <= 1'b0;
      prdata_ff <= 32'h0;
      slverr_ff <= 1'b0;
    end else if (PSEL && PENABLE && !rdy_ff) begin
      rdy_ff <= 1'b1;
      slverr_ff <= !mapped;
      prdata_ff <= (idx == IDX_RT_DIV) ? {16'h0000, rt_div_ff} : {24'h000000, rd_mux};
    end else begin
      rdy_ff <= 1'b0;
      slverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl1_ff <= 8'h00;
      ctrl2_ff <= 8'h00;
      baud_ff <= 8'h00;
      tx_bit8_ff <= 1'b0;
      tx_buf_ff <= 8'h00;
      rt_div_ff <= RT_DIV_RST;
    end else if (wr) begin
      case (idx)
        IDX_CTRL_ONE: ctrl1_ff <= PWDATA[7:0];
        IDX_CTRL_TWO: ctrl2_ff <= PWDATA[7:0];
        IDX_CTRL_THREE: tx_bit8_ff <= PWDATA[6];
        IDX_DATA: tx_buf_ff <= PWDATA[7:0];
        IDX_BAUD: baud_ff <= PWDATA[7:0];
        IDX_RT_DIV: rt_div_ff <= PWDATA[15:0];
        default: ctrl1_ff <= ctrl1_ff;
      endcase
    end
  end

  // Status read arms the clearing access to the data register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      arm1_ff <= 1'b0;
      arm2_ff <= 1'b0;
    end else if (done && mapped) begin
      if (!PWRITE && idx == IDX_STATUS_ONE) arm1_ff <= 1'b1;
      else if (idx == IDX_DATA) arm1_ff <= 1'b0;
      if (!PWRITE && idx == IDX_STATUS_TWO) arm2_ff <= 1'b1;
      else if (idx == IDX_DATA) arm2_ff <= 1'b0;
    end
  end

  assign tx_clr = wr && idx == IDX_DATA && arm1_ff && tef_ff;
  assign rx_clr = rd && idx == IDX_DATA && arm1_ff;
  assign rx_data_clr = rd && idx == IDX_DATA && arm2_ff;

  rt_divider #(.W(16)) u_div (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .en(interface_enable),
    .div(rt_div_ff),
    .tick(rt_tick)
  );

  // Transmitter bit timing
  assign bit_tick = rt_tick && tx_rt_ff == RT16;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) tx_rt_ff <= 4'h0;
    else if (!interface_enable) tx_rt_ff <= 4'h0;
    else if (rt_tick) tx_rt_ff <= tx_rt_ff + 4'h1;
  end

  assign load_frame = bit_tick && tx_left_ff <= 4'h1 && ctrl2_ff[BIT_TX_EN] &&
                      !ctrl2_ff[BIT_SEND_BRK] && tx_st_ff != TX_BREAK &&
                      !pre_pend_ff && !tef_ff;

  // Enable rising edge queues one idle character
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      te_q_ff <= 1'b0;
      pre_pend_ff <= 1'b0;
    end else begin
      te_q_ff <= ctrl2_ff[BIT_TX_EN] && interface_enable;
      if (!interface_enable) pre_pend_ff <= 1'b0;
      else if (ctrl2_ff[BIT_TX_EN] && !te_q_ff) pre_pend_ff <= 1'b1;
      else if (tx_st_ff == TX_PRE) pre_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= 14'h3FFF;
      tx_left_ff <= 4'h0;
    end else if (!interface_enable) begin
      tx_st_ff <= TX_IDLE;
      tx_left_ff <= 4'h0;
    end else if (bit_tick) begin
      if (tx_left_ff > 4'h1) begin
        tx_sh_ff <= {1'b1, tx_sh_ff[13:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
      end else if (!ctrl2_ff[BIT_TX_EN]) begin
        tx_st_ff <= TX_IDLE;
        tx_left_ff <= 4'h0;
      end else if (ctrl2_ff[BIT_SEND_BRK]) begin
        tx_st_ff <= TX_BREAK;
        tx_sh_ff <= 14'h0000;
        tx_left_ff <= frame_len + (baud_ff[BIT_LONG_BRK] ? LONG_BRK_EXTRA : 4'h0);
      end else if (tx_st_ff == TX_BREAK) begin
        tx_st_ff <= TX_TAIL;
        tx_sh_ff <= 14'h3FFF;
        tx_left_ff <= 4'h1;
      end else if (pre_pend_ff) begin
        tx_st_ff <= TX_PRE;
        tx_sh_ff <= 14'h3FFF;
        tx_left_ff <= frame_len;
      end else if (load_frame) begin
        tx_st_ff <= TX_FRAME;
        tx_sh_ff <= m9 ? {3'h7, 1'b1, tx_bit8_ff, tx_buf_ff, 1'b0} :
                         {4'hF, 1'b1, tx_buf_ff, 1'b0};
        tx_left_ff <= frame_len;
      end else begin
        tx_st_ff <= TX_IDLE;
        tx_left_ff <= 4'h0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      txd_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      txd_ff <= ((tx_st_ff == TX_IDLE) ? 1'b1 : tx_sh_ff[0]) ^ inv;
      oe_n_ff <= !interface_enable;
    end
  end
  assign TXD_OUT = txd_ff;
  assign TXD_OE_N = oe_n_ff;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tef_ff <= 1'b1;
      tcf_ff <= 1'b1;
    end else begin
      if (load_frame) tef_ff <= 1'b1;
      else if (tx_clr) tef_ff <= 1'b0;
      tcf_ff <= tef_ff && !tx_clr && tx_st_ff == TX_IDLE && !pre_pend_ff &&
                !(interface_enable && ctrl2_ff[BIT_TX_EN] && ctrl2_ff[BIT_SEND_BRK]);
    end
  end
  assign TX_IRQ = (tef_ff && ctrl2_ff[BIT_TE_IE]) || (tcf_ff && ctrl2_ff[BIT_TC_IE]);

  // Receiver frame assembly
  assign sif.rt_tick = rt_tick;
  assign sif.rx_enable = interface_enable && ctrl2_ff[BIT_RX_EN];
  assign sif.frame_end = done_ff;

  rx_sampler u_smp (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .rxd_pin(RXD_IN),
    .sif(sif)
  );

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_act_ff <= 1'b0;
      rx_extra_ff <= 1'b0;
      rx_zero_ff <= 1'b0;
      rx_noise_ff <= 1'b0;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
      done_ff <= 1'b0;
      done_brk_ff <= 1'b0;
      done_fe_ff <= 1'b0;
      done_nf_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!sif.rx_enable) begin
        rx_act_ff <= 1'b0;
      end else if (sif.start_ok) begin
        rx_act_ff <= 1'b1;
        rx_extra_ff <= 1'b0;
        rx_zero_ff <= 1'b1;
        rx_noise_ff <= sif.start_noise;
        rx_cnt_ff <= 4'h0;
      end else if (sif.bit_stb && rx_act_ff) begin
        if (rx_extra_ff) begin
          rx_act_ff <= 1'b0;
          done_ff <= 1'b1;
          done_brk_ff <= !sif.bit_val;
          done_fe_ff <= 1'b1;
          done_nf_ff <= rx_noise_ff || sif.bit_noise;
        end else if (rx_cnt_ff < (m9 ? 4'h9 : 4'h8)) begin
          rx_sh_ff <= {sif.bit_val, rx_sh_ff[8:1]};
          rx_zero_ff <= rx_zero_ff && !sif.bit_val;
          rx_noise_ff <= rx_noise_ff || sif.bit_noise;
          rx_cnt_ff <= rx_cnt_ff + 4'h1;
        end else if (!sif.bit_val && rx_zero_ff && baud_ff[BIT_LONG_BRK]) begin
          rx_extra_ff <= 1'b1;
          rx_noise_ff <= rx_noise_ff || sif.bit_noise;
        end else begin
          rx_act_ff <= 1'b0;
          done_ff <= 1'b1;
          done_brk_ff <= !sif.bit_val && rx_zero_ff;
          done_fe_ff <= !sif.bit_val;
          done_nf_ff <= rx_noise_ff || sif.bit_noise;
        end
      end
    end
  end

  // Receive flags; a new event wins over a software clear
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rff_ff <= 1'b0;
      orf_ff <= 1'b0;
      nf_ff <= 1'b0;
      fe_ff <= 1'b0;
      bkf_ff <= 1'b0;
      rx_buf_ff <= 8'h00;
      rx_bit8_ff <= 1'b0;
    end else if (done_ff) begin
      rff_ff <= 1'b1;
      if (rff_ff && !rx_clr) begin
        orf_ff <= 1'b1;
      end else begin
        rx_buf_ff <= done_brk_ff ? 8'h00 : (m9 ? rx_sh_ff[7:0] : rx_sh_ff[8:1]);
        rx_bit8_ff <= done_brk_ff ? 1'b0 : (m9 ? rx_sh_ff[8] : rx_sh_ff[8]);
        if (rx_clr) orf_ff <= 1'b0;
      end
      fe_ff <= done_fe_ff || (fe_ff && !rx_clr);
      nf_ff <= done_nf_ff || (nf_ff && !rx_clr);
      bkf_ff <= done_brk_ff || (bkf_ff && !rx_data_clr);
    end else begin
      if (rx_clr) begin
        rff_ff <= 1'b0;
        orf_ff <= 1'b0;
        nf_ff <= 1'b0;
        fe_ff <= 1'b0;
      end
      if (rx_data_clr) bkf_ff <= 1'b0;
    end
  end
  assign RX_IRQ = rff_ff && ctrl2_ff[BIT_RF_IE];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  a_idle_high: assert property (tx_st_ff == TX_IDLE && !inv && interface_enable |=> TXD_OUT)
    else $error("line not idle high");
  a_inv_idle: assert property (tx_st_ff == TX_IDLE && $stable(inv) && inv |=> !TXD_OUT)
    else $error("inverted idle not low");
  a_frame_bits: assert property (load_frame && interface_enable |=> !tx_sh_ff[0] &&
    tx_sh_ff[frame_len - 4'h1] && tx_left_ff == frame_len)
    else $error("frame start or stop bit wrong");
  a_empty_set: assert property (load_frame |=> tef_ff)
    else $error("empty flag not set on load");
  a_break_low: assert property (tx_st_ff == TX_BREAK && !inv && $stable(inv) |=> !TXD_OUT)
    else $error("break bit not zero");
  a_tail_one: assert property ($fell(tx_st_ff == TX_BREAK) && interface_enable |->
    tx_st_ff == TX_TAIL || tx_st_ff == TX_BREAK || !ctrl2_ff[BIT_TX_EN])
    else $error("no one bit after break");
  a_release: assert property (!interface_enable |=> TXD_OE_N && tx_st_ff == TX_IDLE)
    else $error("pins not released");
  a_rx_full: assert property (done_ff |=> rff_ff)
    else $error("receive full not set");
  a_break_rx: assert property (done_ff && done_brk_ff && !(rff_ff && !rx_clr) |=>
    rx_buf_ff == 8'h00 && !rx_bit8_ff && fe_ff && bkf_ff)
    else $error("break effects missing");
  a_bit8_copy: assert property (done_ff && !done_brk_ff && !m9 && !(rff_ff && !rx_clr) |=>
    rx_bit8_ff == rx_buf_ff[7])
    else $error("bit 8 not copy of bit 7");
  a_preamble: assert property (interface_enable && ctrl2_ff[BIT_TX_EN] && !te_q_ff |=>
    pre_pend_ff [*1] ##0 !load_frame)
    else $error("preamble not queued first");

  c_frame_sent: cover property (tx_st_ff == TX_FRAME ##1 tx_st_ff == TX_IDLE);
  c_break_rx: cover property (done_ff && done_brk_ff);
  c_noise_rx: cover property (done_ff && done_nf_ff);
  c_break_tx: cover property (tx_st_ff == TX_BREAK ##1 tx_st_ff == TX_TAIL);
endmodule
`default_nettype wire

// *** tb/serial_peer.sv ***
// Purpose: Remote serial peer driving the receive line and capturing the transmit line
// Assumes: Sample divisor of one, so a bit lasts 16 system clocks
// Notes: Line rests high outside frames
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Sends n bits, bit 0 first
  task automatic send(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (16) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // Mid-bit samples of one frame
  task automatic grab(output logic [10:0] f);
    wait (txd === 1'b0);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd;
      repeat (16) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/test_async_serial_tx_rx_core.sv ***
// Purpose: Self-checking bench for the serial core
// Assumes: Sample divisor set to one
// Notes: Frames checked at the pins
`timescale 1ns/10ps
`default_nettype none
module test_async_serial_tx_rx_core
  import serial_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, txd_oe_n, tx_irq, rx_irq;
  logic [31:0] q;
  logic [10:0] f;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  serial_core dut (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RXD_IN(rxd), .TXD_OUT(txd), .TXD_OE_N(txd_oe_n),
    .TX_IRQ(tx_irq), .RX_IRQ(rx_irq));
  serial_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic wait_rx;
    for (int i = 0; i < 400 && rx_irq !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset;
    chk("txd idle", 1, txd);
    chk("oe_n", 1, txd_oe_n);
    apb(0, IDX_STATUS_ONE, 0);
    chk("status one", 32'hC0, q);
    apb(0, 6'h3F, 0);
    chk("slverr", 1, pslverr);
    $display("test reset done");
  endtask
  task automatic t_tx;
    apb(1, IDX_RT_DIV, 32'h1);
    apb(1, IDX_CTRL_ONE, 32'h40);
    apb(1, IDX_CTRL_TWO, 32'h88);
    apb(0, IDX_STATUS_ONE, 0);
    apb(1, IDX_DATA, 32'hA5);
    @(posedge clk);
    chk("tx irq clear", 0, tx_irq);
    peer.grab(f);
    chk("tx frame", {2'b11, 8'hA5, 1'b0}, f);
    chk("oe_n on", 0, txd_oe_n);
    chk("tx irq", 1, tx_irq);
    $display("test tx done");
  endtask
  task automatic t_rx;
    apb(1, IDX_CTRL_TWO, 32'h2C);
    peer.send({1'b1, 8'hA5, 1'b0}, 10);
    wait_rx;
    chk("rx irq", 1, rx_irq);
    apb(0, IDX_STATUS_ONE, 0);
    chk("rx full", 32'h20, q & 32'h26);
    apb(0, IDX_CTRL_THREE, 0);
    chk("rx bit8", 32'h80, q & 32'h80);
    apb(0, IDX_DATA, 0);
    chk("rx data", 32'hA5, q);
    $display("test rx done");
  endtask
  task automatic t_brk;
    peer.send(16'h0800, 12);
    wait_rx;
    apb(0, IDX_STATUS_ONE, 0);
    chk("brk status", 32'h22, q & 32'h22);
    apb(0, IDX_STATUS_TWO, 0);
    chk("brk flag", 32'h2, q & 32'h2);
    apb(0, IDX_DATA, 0);
    chk("brk data", 0, q);
    apb(0, IDX_CTRL_THREE, 0);
    chk("brk bit8", 0, q & 32'h80);
    $display("test break done");
  endtask
  task automatic t_tx9;
    int t0;
    apb(1, IDX_CTRL_ONE, 32'h50);
    apb(1, IDX_CTRL_THREE, 32'h40);
    apb(0, IDX_STATUS_ONE, 0);
    apb(1, IDX_DATA, 32'h3C);
    peer.grab(f);
    chk("tx9 frame", {1'b1, 1'b1, 8'h3C, 1'b0}, f);
    apb(0, IDX_STATUS_ONE, 0);
    apb(1, IDX_DATA, 32'h55);
    wait (txd === 1'b0);
    t0 = cyc;
    apb(1, IDX_CTRL_TWO, 32'h24);
    apb(1, IDX_CTRL_TWO, 32'h2C);
    apb(0, IDX_STATUS_ONE, 0);
    apb(1, IDX_DATA, 32'h55);
    wait (cyc == t0 + 184);
    chk("idle queued", 1, txd);
    wait (cyc == t0 + 360);
    chk("start after idle", 0, txd);
    wait (cyc == t0 + 560);
    $display("test 9-bit tx done");
  endtask
  task automatic t_brk_tx;
    peer.send({1'b1, 1'b1, 8'h5A, 1'b0}, 11);
    wait_rx;
    apb(0, IDX_STATUS_ONE, 0);
    apb(0, IDX_CTRL_THREE, 0);
    chk("rx9 bit8", 32'h80, q & 32'h80);
    apb(0, IDX_DATA, 0);
    chk("rx9 data", 32'h5A, q);
    apb(1, IDX_CTRL_TWO, 32'h2D);
    wait (txd === 1'b0);
    apb(0, IDX_STATUS_ONE, 0);
    chk("tc in break", 0, q & 32'h40);
    apb(1, IDX_DATA, 32'hC3);
    repeat (200) @(posedge clk);
    chk("break low", 0, txd);
    apb(1, IDX_CTRL_TWO, 32'h2C);
    wait (txd === 1'b1);
    repeat (8) @(posedge clk);
    chk("break tail", 1, txd);
    repeat (16) @(posedge clk);
    chk("start after tail", 0, txd);
    repeat (200) @(posedge clk);
    apb(0, IDX_STATUS_ONE, 0);
    chk("tx complete", 32'hC0, q & 32'hC0);
    $display("test break tx done");
  endtask
  task automatic t_ctl;
    apb(1, IDX_CTRL_ONE, 32'h60);
    repeat (20) @(posedge clk);
    chk("inv idle", 0, txd);
    apb(1, IDX_CTRL_ONE, 32'h0);
    repeat (4) @(posedge clk);
    chk("oe_n off", 1, txd_oe_n);
    $display("test control done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_tx;
    t_rx;
    t_brk;
    t_tx9;
    t_brk_tx;
    t_ctl;
    report_and_stop;
  end
endmodule
`default_nettype wire
